// [pkg/perf_mon_pkg.sv]
// package: constants, types and helpers of the traffic throughput monitor
// assumes: one 200 MHz core clock; 64-bit beats with 8 byte-keep bits
package perf_mon_pkg;

  localparam int unsigned ENGINES      = 4;
  localparam int unsigned CNT_W        = 32;
  localparam int unsigned BEAT_BYTES   = 8;

  // engines 0,1 card_to_system; engines 2,3 system_to_card
  localparam int unsigned ENG_CARD_TO_SYSTEM_0 = 0;
  localparam int unsigned ENG_SYSTEM_TO_CARD_0 = 2;

  // refresh interval
  localparam longint unsigned CLK_HZ        = 64'd200_000_000;
  localparam longint unsigned INTERVAL_S    = 64'd1;
  localparam longint unsigned INTERVAL_CYC  = INTERVAL_S * CLK_HZ;

  // packet header first dword fields
  localparam int unsigned HDR_HAS_DATA_BIT = 30;
  localparam int unsigned HDR_TYPE_LSB     = 24;
  localparam int unsigned HDR_LEN_LSB      = 0;
  localparam logic [4:0]  TYPE_MEM_WRITE   = 5'h00;
  localparam logic [4:0]  TYPE_CPL         = 5'h0A;
  localparam logic [10:0] LEN_ZERO_DWORDS  = 11'h400;

  localparam logic [CNT_W-1:0] CNT_RESET   = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_SOP  = 2'b01,
    ST_BODY = 2'b10
  } pkt_state_e;

  // number of valid bytes in a beat
  function automatic logic [CNT_W-1:0] keep_bytes(input logic [BEAT_BYTES-1:0] keep);
    logic [CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < BEAT_BYTES; i++) begin
      n = n + {31'h0000_0000, keep[i]};
    end
    return n;
  endfunction

  // payload bytes of a packet given its first header dword, if of type typ with data
  function automatic logic [CNT_W-1:0] hdr_payload(input logic [31:0] dw0,
                                                   input logic [4:0]  typ);
    logic [10:0] len;
    len = {1'b0, dw0[HDR_LEN_LSB +: 10]};
    if (len == 11'h000) begin
      len = LEN_ZERO_DWORDS;
    end
    if (dw0[HDR_HAS_DATA_BIT] && (dw0[HDR_TYPE_LSB +: 5] == typ)) begin
      return {19'h0_0000, len, 2'b00};
    end
    return CNT_RESET;
  endfunction

endpackage

// [pkg/acc_if.sv]
// interface: one accumulator channel, increment and interval tick in, published count out
// assumes: all signals in the core clock domain
`timescale 1ns/10ps
interface acc_if;
  logic [31:0] inc;
  logic        tick;
  logic [31:0] count;

  modport src  (output inc, output tick, input count);
  modport sink (input inc, input tick, output count);
endinterface

// [rtl/byte_accum.sv]
// module: live byte accumulator with a published snapshot per interval
// assumes: tick is a one-cycle pulse; ce freezes all state
`timescale 1ns/10ps
module byte_accum (
  // clock and control
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // channel
  acc_if.sink       ch
);

  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [31:0] next_count;

  always_comb begin
    if (ch.tick) begin
      next_acc   = ch.inc;               // see R10
      next_count = acc;                  // see R6
    end else begin
      next_acc   = acc + ch.inc;         // see R1
      next_count = ch.count;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      acc      <= perf_mon_pkg::CNT_RESET;
      ch.count <= perf_mon_pkg::CNT_RESET;
    end else if (ce_i) begin
      acc      <= next_acc;
      ch.count <= next_count;
    end
  end

  property p_snap_on_tick;
    @(posedge core_clk_i) disable iff (rst_i)
      (!rst_i && ce_i && ch.tick) |=> (ch.count == $past(acc));
  endproperty
  a_snap_on_tick: assert property (p_snap_on_tick) else $error("snapshot not taken"); // see R6

  property p_clear_on_tick;
    @(posedge core_clk_i) disable iff (rst_i)
      (!rst_i && ce_i && ch.tick) |=> (acc == $past(ch.inc));
  endproperty
  a_clear_on_tick: assert property (p_clear_on_tick) else $error("accumulator lost bytes"); // see R10

  property p_hold_between;
    @(posedge core_clk_i) disable iff (rst_i)
      (!rst_i && ce_i && !ch.tick) |=> $stable(ch.count);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("count moved mid-interval"); // see R6

  property p_accumulate;
    @(posedge core_clk_i) disable iff (rst_i)
      (!rst_i && ce_i && !ch.tick) |=> (acc == $past(acc) + $past(ch.inc));
  endproperty
  a_accumulate: assert property (p_accumulate) else $error("accumulator add wrong"); // see R1

endmodule // byte_accum

// [rtl/perf_monitor.sv]
// module: traffic throughput monitor for a DMA reference_design endpoint
// assumes: taps are synchronous to core_clk_i; 64-bit beats, dword 0 in bits 31:0
//
// Contract
// R1: each DMA engine has its own counter of payload bytes handed to user.
// R2: count every byte on transmit transaction interface, headers included.
// R3: count every byte on receive transaction interface, headers included.
// R4: transmit payload counter adds only memory-write data, headers excluded.
// R5: receive payload counter adds only completion data, headers excluded.
// R6: published values refresh every one second interval.
// R7: host polls the registers about once per second.
// R8: partly filled 64-bit beats count only their valid bytes.
// R9: four engine counters: two card_to_system, two system_to_card.
// R10: at each boundary copy accumulator out and restart from zero losslessly.
`timescale 1ns/10ps
module perf_monitor #(
  parameter int unsigned INTERVAL_CYCLES = 32'(perf_mon_pkg::INTERVAL_CYC)
) (
  // clock, reset, enable
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // engine user streams
  input  wire logic [3:0]              eng_valid_i,
  input  wire logic [3:0]              eng_ready_i,
  input  wire logic [3:0][7:0]         eng_keep_i,
  // transmit transaction interface
  input  wire logic                    tx_tvalid_i,
  input  wire logic                    tx_tready_i,
  input  wire logic                    tx_tlast_i,
  input  wire logic [7:0]              tx_tkeep_i,
  input  wire logic [63:0]             tx_tdata_i,
  // receive transaction interface
  input  wire logic                    rx_tvalid_i,
  input  wire logic                    rx_tready_i,
  input  wire logic                    rx_tlast_i,
  input  wire logic [7:0]              rx_tkeep_i,
  input  wire logic [63:0]             rx_tdata_i,
  // published counts and interval tick
  output logic      [3:0][31:0]        eng_bytes_o,
  output logic      [31:0]             tx_util_o,
  output logic      [31:0]             rx_util_o,
  output logic      [31:0]             tx_payload_o,
  output logic      [31:0]             rx_payload_o,
  output logic                         interval_tick_o
);

  localparam int unsigned NCH = 8;

  logic                    tx_beat;
  logic                    rx_beat;
  logic [31:0]             tcnt;
  logic [31:0]             next_tcnt;
  logic                    tick;
  logic                    next_interval_tick;
  perf_mon_pkg::pkt_state_e tx_state;
  perf_mon_pkg::pkt_state_e rx_state;
  perf_mon_pkg::pkt_state_e next_tx_state;
  perf_mon_pkg::pkt_state_e next_rx_state;
  logic [NCH-1:0][31:0]    inc;
  logic [NCH-1:0][31:0]    cnt;

  assign tx_beat = tx_tvalid_i && tx_tready_i;
  assign rx_beat = rx_tvalid_i && rx_tready_i;

  // interval timer
  always_comb begin
    tick               = (tcnt == INTERVAL_CYCLES - 32'd1);
    next_tcnt          = tick ? 32'h0000_0000 : tcnt + 32'd1;  // see R6
    next_interval_tick = tick;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tcnt            <= 32'h0000_0000;
      interval_tick_o <= 1'b0;
    end else if (ce_i) begin
      tcnt            <= next_tcnt;
      interval_tick_o <= next_interval_tick;
    end
  end

  // next packet state of one transaction interface; illegal codes fall back to a start
  function automatic perf_mon_pkg::pkt_state_e pkt_next(input perf_mon_pkg::pkt_state_e cur,
                                                        input logic                     beat,
                                                        input logic                     last);
    perf_mon_pkg::pkt_state_e nxt;
    nxt = cur;
    unique case (cur)
      perf_mon_pkg::ST_SOP: begin
        if (beat && !last) begin
          nxt = perf_mon_pkg::ST_BODY;
        end
      end
      perf_mon_pkg::ST_BODY: begin
        if (beat && last) begin
          nxt = perf_mon_pkg::ST_SOP;
        end
      end
      default: begin
        nxt = perf_mon_pkg::ST_SOP;
      end
    endcase
    return nxt;
  endfunction

  // packet start tracking on both transaction interfaces
  always_comb begin
    next_tx_state = pkt_next(tx_state, tx_beat, tx_tlast_i);
    next_rx_state = pkt_next(rx_state, rx_beat, rx_tlast_i);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_state <= perf_mon_pkg::ST_SOP;
      rx_state <= perf_mon_pkg::ST_SOP;
    end else if (ce_i) begin
      tx_state <= next_tx_state;
      rx_state <= next_rx_state;
    end
  end

  // per-cycle byte increments
  always_comb begin
    for (int e = 0; e < 4; e++) begin
      inc[e] = (eng_valid_i[e] && eng_ready_i[e]) ?
               perf_mon_pkg::keep_bytes(eng_keep_i[e]) : 32'h0000_0000;  // see R1, R8
    end
    inc[4] = tx_beat ? perf_mon_pkg::keep_bytes(tx_tkeep_i) : 32'h0000_0000; // see R2, R8
    inc[5] = rx_beat ? perf_mon_pkg::keep_bytes(rx_tkeep_i) : 32'h0000_0000; // see R3, R8
    inc[6] = (tx_beat && tx_state == perf_mon_pkg::ST_SOP) ?
             perf_mon_pkg::hdr_payload(tx_tdata_i[31:0], perf_mon_pkg::TYPE_MEM_WRITE) :
             32'h0000_0000;                                              // see R4
    inc[7] = (rx_beat && rx_state == perf_mon_pkg::ST_SOP) ?
             perf_mon_pkg::hdr_payload(rx_tdata_i[31:0], perf_mon_pkg::TYPE_CPL) :
             32'h0000_0000;                                              // see R5
  end

  // one accumulator per published count
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    acc_if ch ();
    assign ch.inc  = inc[g];
    assign ch.tick = tick;
    assign cnt[g]  = ch.count;
    byte_accum u_acc (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .ch         (ch)
    );
  end

  // accumulator snapshot registers drive the outputs directly
  assign eng_bytes_o  = cnt[3:0];   // see R9
  assign tx_util_o    = cnt[4];
  assign rx_util_o    = cnt[5];
  assign tx_payload_o = cnt[6];
  assign rx_payload_o = cnt[7];

  property p_eng_idle_zero;
    @(posedge core_clk_i) disable iff (rst_i)
      !(eng_valid_i[0] && eng_ready_i[0]) |-> (inc[0] == 32'h0000_0000);
  endproperty
  a_eng_idle_zero: assert property (p_eng_idle_zero) else $error("engine counted idle"); // see R1

  property p_tx_util;
    @(posedge core_clk_i) disable iff (rst_i)
      (tx_beat && tx_tkeep_i == 8'h0F) |-> (inc[4] == 32'd4);
  endproperty
  a_tx_util: assert property (p_tx_util) else $error("tx partial beat miscounted"); // see R2

  property p_rx_util;
    @(posedge core_clk_i) disable iff (rst_i)
      (rx_beat && rx_tkeep_i == 8'hFF) |-> (inc[5] == 32'd8);
  endproperty
  a_rx_util: assert property (p_rx_util) else $error("rx full beat miscounted"); // see R3

  property p_tx_body_no_payload;
    @(posedge core_clk_i) disable iff (rst_i)
      (!rst_i && ce_i && tx_beat && !tx_tlast_i) |=> (inc[6] == 32'h0000_0000);
  endproperty
  a_tx_body_no_payload: assert property (p_tx_body_no_payload) else $error("tx body payload"); // see R4

  property p_rx_type_filter;
    @(posedge core_clk_i) disable iff (rst_i)
      (rx_state == perf_mon_pkg::ST_SOP && rx_tdata_i[28:24] != 5'h0A) |->
        (inc[7] == 32'h0000_0000);
  endproperty
  a_rx_type_filter: assert property (p_rx_type_filter) else $error("non-completion counted"); // see R5

  property p_tick_pulse;
    @(posedge core_clk_i) disable iff (rst_i)
      (!rst_i && ce_i && interval_tick_o && INTERVAL_CYCLES > 1) |=> !interval_tick_o;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick wider than one cycle"); // see R6

  property p_tick_follows_wrap;
    @(posedge core_clk_i) disable iff (rst_i)
      (!rst_i && ce_i && tick) |=> (interval_tick_o && tcnt == 32'h0000_0000);
  endproperty
  a_tick_follows_wrap: assert property (p_tick_follows_wrap) else $error("tick misaligned"); // see R10

  property p_tx_sop_next;
    @(posedge core_clk_i) disable iff (rst_i)
      (!rst_i && ce_i && tx_beat && tx_tlast_i) |=> (tx_state == perf_mon_pkg::ST_SOP);
  endproperty
  a_tx_sop_next: assert property (p_tx_sop_next) else $error("tx start lost"); // see R4

  property p_rx_cpl_len;
    @(posedge core_clk_i) disable iff (rst_i)
      (rx_beat && rx_state == perf_mon_pkg::ST_SOP && rx_tdata_i[31:24] == 8'h4A &&
       rx_tdata_i[9:0] == 10'h008) |-> (inc[7] == 32'h0000_0020);
  endproperty
  a_rx_cpl_len: assert property (p_rx_cpl_len) else $error("completion length wrong"); // see R5

  property p_freeze;
    @(posedge core_clk_i) disable iff (rst_i)
      (!rst_i && !ce_i) |=> ($stable(tcnt) && $stable(interval_tick_o) && $stable(rx_state));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled"); // see R6

  c_tick:     cover property (@(posedge core_clk_i) disable iff (rst_i) interval_tick_o);
  c_tx_write: cover property (@(posedge core_clk_i) disable iff (rst_i) inc[6] != 32'h0);
  c_rx_cpl:   cover property (@(posedge core_clk_i) disable iff (rst_i) inc[7] != 32'h0);
  c_partial:  cover property (@(posedge core_clk_i) disable iff (rst_i)
                              tx_beat && tx_tkeep_i == 8'h0F);

endmodule // perf_monitor

// [tb/tap_driver.sv]
// partner: drives the engine user streams and both transaction interfaces
// assumes: one clock; every change lands just after its rising edge
`timescale 1ns/10ps
module tap_driver (
  // clock
  input  wire logic             core_clk_i,
  // engine streams
  output logic      [3:0]       eng_valid_o,
  output logic      [3:0]       eng_ready_o,
  output logic      [3:0][7:0]  eng_keep_o,
  // transaction interfaces, index 0 transmit, 1 receive
  output logic      [1:0]       tvalid_o,
  output logic      [1:0]       tready_o,
  output logic      [1:0]       tlast_o,
  output logic      [1:0][7:0]  tkeep_o,
  output logic      [1:0][63:0] tdata_o
);
  initial begin
    eng_valid_o = 4'h0;
    eng_ready_o = 4'h0;
    eng_keep_o  = 32'h0;
    tvalid_o    = 2'h0;
    tready_o    = 2'h0;
    tlast_o     = 2'h0;
    tkeep_o     = 16'h0;
    tdata_o     = 128'h0;
  end

  // one beat on side s, header dword in bits 31:0; released side shows inverted data
  task automatic beat(input int s, input logic [63:0] d, input logic [7:0] k,
                      input logic l, input logic r);
    @(posedge core_clk_i);
    tvalid_o        <= 2'h1 << s;
    tready_o        <= {r, r};
    tlast_o         <= {l, l};
    tkeep_o         <= {k, k};
    tdata_o[s]      <= d;
    tdata_o[1 - s]  <= ~tdata_o[1 - s];
    eng_valid_o     <= 4'h0;
  endtask

  // one engine cycle; transaction interfaces released
  task automatic eng(input logic [3:0] v, input logic [3:0] r, input logic [31:0] k);
    @(posedge core_clk_i);
    eng_valid_o <= v;
    eng_ready_o <= r;
    eng_keep_o  <= k;
    tvalid_o    <= 2'h0;
    tdata_o     <= ~tdata_o;
  endtask
endmodule // tap_driver

// [tb/tb_top.sv]
// testbench: traffic on all taps, published counts judged once per interval
// assumes: interval shortened by parameter; monitor has no answer per beat
`timescale 1ns/10ps
module tb_top;
  localparam int unsigned N = 64;
  logic             core_clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             ce_i = 1'b1;
  logic [3:0]       ev;
  logic [3:0]       er;
  logic [3:0][7:0]  ek;
  logic [1:0]       tv;
  logic [1:0]       tr;
  logic [1:0]       tl;
  logic [1:0][7:0]  tk;
  logic [1:0][63:0] td;
  logic [3:0][31:0] eb;
  logic [31:0]      txu;
  logic [31:0]      rxu;
  logic [31:0]      txp;
  logic [31:0]      rxp;
  logic             tick;
  int               n_fail = 0;
  int               tests_run = 0;
  int               n;

  always #2.5 core_clk_i = ~core_clk_i;

  tap_driver far (.core_clk_i(core_clk_i), .eng_valid_o(ev), .eng_ready_o(er),
    .eng_keep_o(ek), .tvalid_o(tv), .tready_o(tr), .tlast_o(tl), .tkeep_o(tk), .tdata_o(td));

  perf_monitor #(.INTERVAL_CYCLES(N)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .eng_valid_i(ev), .eng_ready_i(er), .eng_keep_i(ek),
    .tx_tvalid_i(tv[0]), .tx_tready_i(tr[0]), .tx_tlast_i(tl[0]), .tx_tkeep_i(tk[0]),
    .tx_tdata_i(td[0]), .rx_tvalid_i(tv[1]), .rx_tready_i(tr[1]), .rx_tlast_i(tl[1]),
    .rx_tkeep_i(tk[1]), .rx_tdata_i(td[1]), .eng_bytes_o(eb), .tx_util_o(txu),
    .rx_util_o(rxu), .tx_payload_o(txp), .rx_payload_o(rxp), .interval_tick_o(tick));

  task automatic conclude;
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // all eight published counts in one go
  task automatic chk_all(input logic [3:0][31:0] e, input logic [3:0][31:0] u);
    for (int i = 0; i < 4; i++) chk("eng_bytes_o", eb[i], e[i]);
    chk("tx_util_o", txu, u[3]);
    chk("rx_util_o", rxu, u[2]);
    chk("tx_payload_o", txp, u[1]);
    chk("rx_payload_o", rxp, u[0]);
  endtask

  // count edges until the next tick, bounded; host reads once per interval
  task automatic wait_tick(output int cnt);
    cnt = 0;
    repeat (3 * N) begin
      far.eng(4'h0, 4'h0, 32'h0);
      cnt++;
      #1;
      if (tick === 1'b1) return;
    end
    chk("interval_tick_o", 32'h0, 32'h1);
    conclude;
  endtask

  task automatic sc_mix;
    far.eng(4'hF, 4'hF, {8'h80, 8'h01, 8'h0F, 8'hFF});
    far.eng(4'h1, 4'h0, 32'hFFFF_FFFF);
    far.eng(4'h8, 4'h8, 32'hFE00_0000);
    far.beat(0, 64'h0000_0000_4000_0002, 8'hFF, 1'b0, 1'b1);
    far.beat(0, 64'h4000_0010_4000_0010, 8'hFF, 1'b0, 1'b1);
    far.beat(0, 64'h4000_0010_4000_0010, 8'h0F, 1'b1, 1'b1);
    far.beat(0, 64'h0000_0000_0000_0001, 8'hFF, 1'b0, 1'b1);
    far.beat(0, 64'h0000_0000_4000_0004, 8'h0F, 1'b1, 1'b1);
    far.beat(0, 64'h0000_0000_4000_0000, 8'hFF, 1'b1, 1'b1);
    far.beat(0, 64'h0000_0000_4000_0001, 8'hFF, 1'b1, 1'b0);
    far.beat(1, 64'h0000_0000_4A00_0008, 8'hFF, 1'b0, 1'b1);
    far.beat(1, 64'h4A00_0010_4A00_0010, 8'h0F, 1'b1, 1'b1);
    far.beat(1, 64'h0000_0000_0A00_0001, 8'hFF, 1'b1, 1'b1);
    far.beat(1, 64'h0000_0000_4000_0004, 8'hFF, 1'b1, 1'b1);
    far.beat(1, 64'h0000_0000_4A00_0004, 8'hFF, 1'b1, 1'b1);
    ce_i <= 1'b0;
    far.eng(4'h0, 4'h0, 32'h0);
    ce_i <= 1'b1;
    wait_tick(n);
    // partial beats count kept bytes; payload from header length, zero means 1024 dwords
    chk_all({32'h8, 32'h1, 32'h4, 32'h8}, {32'h28, 32'h1C, 32'h1008, 32'h20});
  endtask

  task automatic sc_idle;
    wait_tick(n);
    chk("interval_length", n, N);
    chk_all(128'h0, 128'h0);
  endtask

  // beats on the two edges around a boundary land in adjacent intervals
  task automatic sc_boundary;
    repeat (N - 3) @(posedge core_clk_i);
    far.eng(4'h1, 4'h1, 32'h0000_0001);
    far.eng(4'h1, 4'h1, 32'h0000_00FF);
    wait_tick(n);
    chk("eng_bytes_o", eb[0], 32'h1);
    wait_tick(n);
    chk("eng_bytes_o", eb[0], 32'h8);
  endtask

  // reset mid-run with traffic standing clears every count; the timer restarts from zero
  task automatic sc_reset;
    far.eng(4'h2, 4'h2, 32'h0000_FF00);
    rst_i <= 1'b1;
    repeat (3) far.eng(4'h2, 4'h2, 32'h0000_FF00);
    rst_i <= 1'b0;
    #1;
    chk_all(128'h0, 128'h0);
    chk("interval_tick_o", tick, 32'h0);
    wait_tick(n);
    chk("reset_interval", n, N);
    chk("eng_bytes_o", eb[1], 32'h8);
  endtask

  initial begin
    repeat (20) @(posedge core_clk_i);
    #1;
    chk_all(128'h0, 128'h0);
    chk("interval_tick_o", tick, 32'h0);
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    wait_tick(n);
    chk("first_interval", n, N);
    sc_mix;
    sc_idle;
    sc_boundary;
    sc_reset;
    conclude;
  end
endmodule // tb_top
